// file: rtl/lfr_defs.svh
// lfr_defs.svh: offsets, field positions, reset values and timing
// Assumes inclusion by the frame host before its module header
`ifndef LFR_DEFS_SVH
`define LFR_DEFS_SVH
`define LFR_OFF_CTRL    8'h00
`define LFR_OFF_ADDR    8'h04
`define LFR_OFF_TXCMD   8'h08
`define LFR_OFF_TXLEN   8'h0C
`define LFR_OFF_TXDATA  8'h10
`define LFR_OFF_STAT    8'h14
`define LFR_OFF_RXDATA  8'h18
`define LFR_OFF_RXCTL   8'h1C
`define LFR_OFF_RXLEN   8'h20
`define LFR_CTRL_EXT    0
`define LFR_CTRL_NRZI   1
`define LFR_CTRL_FCS32  2
`define LFR_STAT_W1C    10'h0F8
`define LFR_FT_S        2'h1
`define LFR_FT_U        2'h2
`define LFR_FLAG        8'h7E
`define LFR_MIN_FLAGS   2'h2
`define LFR_CRC_INIT    32'hFFFFFFFF
`define LFR_POLY16      32'h00008408
`define LFR_POLY32      32'hEDB88320
`define LFR_RES16       32'h0000F0B8
`define LFR_RES32       32'hDEBB20E3
`define LFR_CLK_NS      100
`define LFR_LINE_NS     800
`define LFR_LINE_CYC    (`LFR_LINE_NS / `LFR_CLK_NS)
`endif

// file: rtl/lfr_pkg.sv
// lfr_pkg.sv: types of the frame host
// Assumes the constants of lfr_defs.svh
`default_nettype none
package lfr_pkg;
   typedef enum logic [5:0] {
      TX_FLAG = 6'h01,
      TX_ADDR = 6'h02,
      TX_CTL0 = 6'h04,
      TX_CTL1 = 6'h08,
      TX_DATA = 6'h10,
      TX_FCS  = 6'h20
   } lfr_tph_t;
   typedef struct packed {
      logic       go;
      logic [5:0] rsv;
      logic [4:0] umod;
      logic [1:0] sfunc;
      logic [6:0] nr;
      logic [6:0] ns;
      logic       pf;
      logic       is_cmd;
      logic [1:0] ftype;
   } lfr_cmd_t;
   typedef struct packed {
      logic [7:0]  ph;
      logic        lclk;
      logic        txd;
      logic [2:0]  sync;
      logic        filt;
      logic        prev;
      logic [2:0]  ctrl;
      logic [7:0]  dev_addr;
      logic [7:0]  own_addr;
      lfr_cmd_t    cmd;
      logic        go;
      logic [15:0] tx_len;
      logic [7:0]  tx_byte;
      logic        tx_full;
      lfr_tph_t    tph;
      logic [7:0]  tsh;
      logic [2:0]  tbit;
      logic [2:0]  tones;
      logic [1:0]  tflags;
      logic [15:0] tcnt;
      logic [31:0] tcrc;
      logic [31:0] tfcs;
      logic [1:0]  tfidx;
      logic [7:0]  rraw;
      logic [2:0]  rones;
      logic        rin;
      logic [7:0]  racc;
      logic [2:0]  rbit;
      logic [1:0]  ridx;
      logic        rdrop;
      logic        riscmd;
      logic [31:0] rcrc;
      logic [15:0] rplen;
      logic [15:0] rctl;
      logic [7:0]  raddr;
      logic [15:0] ctl_o;
      logic [15:0] len_o;
      logic [7:0]  addr_o;
      logic        iscmd_o;
      logic [7:0]  rbyte;
      logic        rvalid;
      logic        ok;
      logic        fcserr;
      logic        amiss;
      logic        under;
      logic        over;
      logic [31:0] rdata;
   } lfr_state_t;
endpackage
`default_nettype wire

// file: rtl/lfr_host.sv
// lfr_host.sv: remote station framer driving the serial line
// Assumes a 10 MHz clk, software on the plain register port, and
// a device that shifts its data on the falling edge of line_clk
`timescale 1ns/10ps
`default_nettype none
`include "lfr_defs.svh"

module lfr_host
   import lfr_pkg::*;
#(
   parameter int LINE_DIV = `LFR_LINE_CYC
)
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [31:0] reg_rdata,
   output var  logic        line_clk,
   output var  logic        line_txd,
   input  wire logic        line_rxd
);

   localparam logic [7:0] PH_LAST = 8'(LINE_DIV - 1);
   localparam logic [7:0] PH_HALF = 8'(LINE_DIV / 2);

   lfr_state_t  st_r;
   lfr_state_t  st_nxt;

   // ==========================================================
   // Helpers
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0]  d,
                                            input logic        w32);
      logic [31:0] x;
      logic        fb;
      x = c;
      if (!w32)
         x[31:16] = 16'h0000;
      for (int i = 0; i < 8; i++)
      begin
         fb = x[0] ^ d[i];
         x = {1'h0, x[31:1]};
         if (fb)
            x = x ^ (w32 ? `LFR_POLY32 : `LFR_POLY16);
      end
      return x;
   endfunction

   function automatic logic [15:0] ctl_build(input lfr_cmd_t c,
                                             input logic     ext);
      logic [15:0] v;
      v = 16'h0000;
      if (c.ftype == `LFR_FT_U)
         v[7:0] = {c.umod[4:2], c.pf, c.umod[1:0], 2'h3};
      else if (ext)
         v = {c.nr, c.pf, (c.ftype == `LFR_FT_S) ?
              {4'h0, c.sfunc, 2'h1} : {c.ns, 1'h0}};
      else
         v[7:0] = {c.nr[2:0], c.pf, (c.ftype == `LFR_FT_S) ?
                   {c.sfunc, 2'h1} : {c.ns[2:0], 1'h0}};
      return v;
   endfunction

   logic        w32;
   logic        ext;
   logic        busy;
   logic [15:0] ctl;
   logic        tbit_o;
   logic        tadv;
   logic        body;
   logic        crc_on;
   logic [7:0]  nb;
   logic [31:0] crc_base;
   logic [31:0] fcs;
   logic        rb;
   logic [7:0]  raw_n;
   logic [7:0]  byte_n;
   logic [31:0] res;
   logic [15:0] fcs_n;
   logic [9:0]  status;

   // ==========================================================
   // Next state
   always_comb
   begin
      st_nxt   = st_r;
      w32      = st_r.ctrl[`LFR_CTRL_FCS32];
      ext      = st_r.ctrl[`LFR_CTRL_EXT];
      busy     = st_r.go | (st_r.tph != TX_FLAG);
      ctl      = ctl_build(st_r.cmd, ext);
      tbit_o   = 1'h0;
      tadv     = 1'h0;
      body     = 1'h0;
      crc_on   = 1'h0;
      nb       = `LFR_FLAG;
      crc_base = (st_r.tph == TX_FLAG) ? `LFR_CRC_INIT : st_r.tcrc;
      fcs      = ~st_r.tcrc;
      rb       = 1'h0;
      raw_n    = st_r.rraw;
      byte_n   = st_r.racc;
      res      = w32 ? `LFR_RES32 : `LFR_RES16;
      fcs_n    = w32 ? 16'h0004 : 16'h0002;
      status   = {st_r.rin, st_r.iscmd_o, st_r.over, st_r.under,
                  st_r.amiss, st_r.fcserr, st_r.ok, st_r.rvalid,
                  ~st_r.tx_full, busy};
      if (!w32)
         fcs[31:16] = 16'h0000;

      // ========================================================
      // Line clock divider and input synchroniser
      st_nxt.ph   = (st_r.ph == PH_LAST) ? 8'h00 : st_r.ph + 8'h01;
      st_nxt.lclk = (st_nxt.ph >= PH_HALF);
      st_nxt.sync = {st_r.sync[1:0], line_rxd};
      if (st_r.sync[1] == st_r.sync[2])
         st_nxt.filt = st_r.sync[2];

      // ========================================================
      // Register reads and clears
      st_nxt.rdata = 32'h00000000;
      if (reg_rd)
      begin
         if (reg_addr == `LFR_OFF_CTRL)
            st_nxt.rdata = {29'h0, st_r.ctrl};
         else if (reg_addr == `LFR_OFF_ADDR)
            st_nxt.rdata = {16'h0, st_r.own_addr, st_r.dev_addr};
         else if (reg_addr == `LFR_OFF_TXCMD)
            st_nxt.rdata = st_r.cmd;
         else if (reg_addr == `LFR_OFF_TXLEN)
            st_nxt.rdata = {16'h0, st_r.tx_len};
         else if (reg_addr == `LFR_OFF_STAT)
            st_nxt.rdata = {22'h0, status};
         else if (reg_addr == `LFR_OFF_RXDATA)
         begin
            st_nxt.rdata  = {24'h0, st_r.rbyte};
            st_nxt.rvalid = 1'h0;
         end
         else if (reg_addr == `LFR_OFF_RXCTL)
            st_nxt.rdata = {16'h0, st_r.ctl_o};
         else if (reg_addr == `LFR_OFF_RXLEN)
            st_nxt.rdata = {8'h0, st_r.addr_o, st_r.len_o};
      end
      if (reg_wr && reg_addr == `LFR_OFF_STAT)
      begin
         st_nxt.ok     = st_r.ok & ~reg_wdata[3];
         st_nxt.fcserr = st_r.fcserr & ~reg_wdata[4];
         st_nxt.amiss  = st_r.amiss & ~reg_wdata[5];
         st_nxt.under  = st_r.under & ~reg_wdata[6];
         st_nxt.over   = st_r.over & ~reg_wdata[7];
      end

      // ========================================================
      // Transmit bit engine
      if (st_r.ph == 8'h00)
      begin
         if (st_r.tones == 3'h5)
            st_nxt.tones = 3'h0;
         else
         begin
            tbit_o       = st_r.tsh[0];
            st_nxt.tones = (st_r.tph != TX_FLAG && tbit_o) ?
                           st_r.tones + 3'h1 : 3'h0;
            st_nxt.tsh   = {1'h0, st_r.tsh[7:1]};
            st_nxt.tbit  = st_r.tbit + 3'h1;
            tadv         = (st_r.tbit == 3'h7);
         end
         st_nxt.txd = st_r.ctrl[`LFR_CTRL_NRZI] ?
                      (tbit_o ? st_r.txd : ~st_r.txd) : tbit_o;
      end
      if (tadv)
      begin
         case (st_r.tph)
            TX_FLAG:
            begin
               if (st_r.go && st_r.tflags >= `LFR_MIN_FLAGS)
               begin
                  st_nxt.tph  = TX_ADDR;
                  nb          = st_r.cmd.is_cmd ? st_r.dev_addr :
                                st_r.own_addr;
                  crc_on      = 1'h1;
                  st_nxt.go   = 1'h0;
                  st_nxt.tcnt = 16'h0000;
               end
               else if (st_r.tflags != 2'h3)
                  st_nxt.tflags = st_r.tflags + 2'h1;
            end
            TX_ADDR:
            begin
               st_nxt.tph = TX_CTL0;
               nb         = ctl[7:0];
               crc_on     = 1'h1;
            end
            TX_CTL0:
            begin
               if (ext && st_r.cmd.ftype != `LFR_FT_U)
               begin
                  st_nxt.tph = TX_CTL1;
                  nb         = ctl[15:8];
                  crc_on     = 1'h1;
               end
               else
                  body = 1'h1;
            end
            TX_CTL1:
               body = 1'h1;
            TX_DATA:
               body = 1'h1;
            TX_FCS:
            begin
               if (st_r.tfidx == (w32 ? 2'h3 : 2'h1))
               begin
                  st_nxt.tph    = TX_FLAG;
                  st_nxt.tflags = 2'h1;
               end
               else
               begin
                  nb           = st_r.tfcs[7:0];
                  st_nxt.tfcs  = {8'h00, st_r.tfcs[31:8]};
                  st_nxt.tfidx = st_r.tfidx + 2'h1;
               end
            end
            default:
               st_nxt.tph = TX_FLAG;
         endcase
         if (body)
         begin
            if (st_r.tcnt != st_r.tx_len)
            begin
               st_nxt.tph  = TX_DATA;
               nb          = st_r.tx_byte;
               crc_on      = 1'h1;
               st_nxt.tcnt = st_r.tcnt + 16'h0001;
               if (st_r.tx_full)
                  st_nxt.tx_full = 1'h0;
               else
                  st_nxt.under = 1'h1;
            end
            else
            begin
               st_nxt.tph   = TX_FCS;
               nb           = fcs[7:0];
               st_nxt.tfcs  = {8'h00, fcs[31:8]};
               st_nxt.tfidx = 2'h0;
            end
         end
         if (crc_on)
            st_nxt.tcrc = crc_byte(crc_base, nb, w32);
         st_nxt.tsh = nb;
      end

      // ========================================================
      // Register writes
      if (reg_wr)
      begin
         if (reg_addr == `LFR_OFF_CTRL)
            st_nxt.ctrl = reg_wdata[2:0];
         else if (reg_addr == `LFR_OFF_ADDR)
         begin
            st_nxt.dev_addr = reg_wdata[7:0];
            st_nxt.own_addr = reg_wdata[15:8];
         end
         else if (reg_addr == `LFR_OFF_TXCMD && !busy)
         begin
            st_nxt.cmd = reg_wdata;
            st_nxt.go  = reg_wdata[31];
         end
         else if (reg_addr == `LFR_OFF_TXLEN)
            st_nxt.tx_len = reg_wdata[15:0];
         else if (reg_addr == `LFR_OFF_TXDATA)
         begin
            st_nxt.tx_byte = reg_wdata[7:0];
            st_nxt.tx_full = 1'h1;
         end
      end

      // ========================================================
      // Receive engine
      if (st_r.ph == PH_LAST)
      begin
         rb = st_r.ctrl[`LFR_CTRL_NRZI] ? (st_r.filt == st_r.prev) :
              st_r.filt;
         st_nxt.prev  = st_r.filt;
         raw_n        = {rb, st_r.rraw[7:1]};
         st_nxt.rraw  = raw_n;
         st_nxt.rones = !rb ? 3'h0 :
                        (st_r.rones == 3'h7) ? 3'h7 : st_r.rones + 3'h1;
         if (raw_n == `LFR_FLAG)
         begin
            if (st_r.rin && st_r.ridx == 2'h3 && st_r.rplen >= fcs_n)
            begin
               if (st_r.rdrop)
                  st_nxt.amiss = 1'h1;
               else if ((st_r.rcrc & (w32 ? 32'hFFFFFFFF :
                        32'h0000FFFF)) != res)
                  st_nxt.fcserr = 1'h1;
               else
               begin
                  st_nxt.ok      = 1'h1;
                  st_nxt.ctl_o   = st_r.rctl;
                  st_nxt.len_o   = st_r.rplen - fcs_n;
                  st_nxt.addr_o  = st_r.raddr;
                  st_nxt.iscmd_o = st_r.riscmd;
               end
            end
            st_nxt.rin   = 1'h1;
            st_nxt.rbit  = 3'h0;
            st_nxt.ridx  = 2'h0;
            st_nxt.rdrop = 1'h0;
            st_nxt.rcrc  = `LFR_CRC_INIT;
            st_nxt.rplen = 16'h0000;
            st_nxt.rctl  = 16'h0000;
         end
         else if (st_r.rones == 3'h6 && rb)
            st_nxt.rin = 1'h0;
         else if (st_r.rones != 3'h5 && st_r.rin && st_r.rones != 3'h6)
         begin
            byte_n       = {rb, st_r.racc[7:1]};
            st_nxt.racc  = byte_n;
            st_nxt.rbit  = st_r.rbit + 3'h1;
            if (st_r.rbit == 3'h7)
            begin
               st_nxt.rcrc = crc_byte(st_r.rcrc, byte_n, w32);
               case (st_r.ridx)
                  2'h0:
                  begin
                     st_nxt.raddr  = byte_n;
                     st_nxt.rdrop  = (byte_n != st_r.own_addr) &&
                                     (byte_n != st_r.dev_addr);
                     st_nxt.riscmd = (byte_n == st_r.own_addr);
                     st_nxt.ridx   = 2'h1;
                  end
                  2'h1:
                  begin
                     st_nxt.rctl[7:0] = byte_n;
                     st_nxt.ridx = (ext && byte_n[1:0] != 2'h3) ?
                                   2'h2 : 2'h3;
                  end
                  2'h2:
                  begin
                     st_nxt.rctl[15:8] = byte_n;
                     st_nxt.ridx       = 2'h3;
                  end
                  default:
                  begin
                     if (!st_r.rdrop)
                     begin
                        st_nxt.rbyte = byte_n;
                        if (st_nxt.rvalid)
                           st_nxt.over = 1'h1;
                        st_nxt.rvalid = 1'h1;
                     end
                     if (st_r.rplen != 16'hFFFF)
                        st_nxt.rplen = st_r.rplen + 16'h0001;
                  end
               endcase
            end
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         st_r     <= '0;
         st_r.tph <= TX_FLAG;
         st_r.tsh <= `LFR_FLAG;
      end
      else
         st_r <= st_nxt;
   end

   assign reg_rdata = st_r.rdata;
   assign line_clk  = st_r.lclk;
   assign line_txd  = st_r.txd;

endmodule // lfr_host
`default_nettype wire

// file: tb/lfr_props.sv
// lfr_props.sv: port assertions of the frame host
// Assumes a bind to lfr_host with a LINE_DIV of 8
`timescale 1ns/10ps
`default_nettype none
`include "lfr_defs.svh"
module lfr_props
   import lfr_pkg::*;
#(
   parameter int LINE_DIV = 8
)
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        line_clk,
   input wire logic        line_txd,
   input wire logic        line_rxd
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ==========
   // Register port
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   a_rd_unmapped: assert property (
      reg_rd && reg_addr > 8'h20 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_ctrl_back: assert property (
      reg_wr && reg_addr == `LFR_OFF_CTRL ##1 reg_rd
      && reg_addr == `LFR_OFF_CTRL
      |=> reg_rdata == {29'h0, $past(reg_wdata[2:0], 2)})
      else $error("mode readback wrong");
   a_addr_back: assert property (
      reg_wr && reg_addr == `LFR_OFF_ADDR ##1 reg_rd
      && reg_addr == `LFR_OFF_ADDR
      |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 2)})
      else $error("address readback wrong");
   a_stat_upper: assert property (
      reg_rd && reg_addr == `LFR_OFF_STAT |=> reg_rdata[31:10] == 22'h0)
      else $error("status upper bits set");
   // ==========
   // Serial line
   a_clk_high: assert property (
      $rose(line_clk) |-> line_clk [*4] ##1 !line_clk)
      else $error("line clock high phase wrong");
   a_clk_low: assert property (
      $fell(line_clk) |-> !line_clk [*4] ##1 line_clk)
      else $error("line clock low phase wrong");
   a_txd_hold: assert property (line_clk |-> $stable(line_txd))
      else $error("line data moved while clock high");
endmodule // lfr_props
bind lfr_host lfr_props #(.LINE_DIV(LINE_DIV)) u_props (.clk(clk),
   .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .line_clk(line_clk), .line_txd(line_txd), .line_rxd(line_rxd));
`default_nettype wire

// file: tb/lfr_dev.sv
// lfr_dev.sv: behavioural far station on the serial line
// Assumes the host makes line_clk; this end shifts on its fall
`timescale 1ns/10ps
`default_nettype none
`include "lfr_defs.svh"
module lfr_dev
   import lfr_pkg::*;
(
   input  wire logic line_clk,
   input  wire logic line_txd,
   output var  logic line_rxd,
   input  wire logic nrzi,
   input  wire logic fcs32
);
   localparam logic [7:0] FLAG = `LFR_FLAG;
   logic       bq[$];
   logic [7:0] cur[$];
   logic [7:0] fb[$];
   logic [7:0] sh = 8'h00;
   logic [7:0] acc = 8'h00;
   logic       lv = 1'b0;
   logic       pv = 1'b0;
   logic       tb_bit, rb, fok;
   int         on = 0;
   int         nb = 0;
   int         fl = 0;
   int         gap = 0;
   int         nfr = 0;
   initial line_rxd = 1'b0;
   // ==========
   // Check sequence, reflected
   function automatic logic [31:0] crc(input logic [7:0] q[$]);
      logic [31:0] c;
      c = fcs32 ? `LFR_CRC_INIT : 32'h0000FFFF;
      foreach (q[k])
         for (int i = 0; i < 8; i++)
            c = (c[0] ^ q[k][i]) ? (c >> 1)
               ^ (fcs32 ? `LFR_POLY32 : `LFR_POLY16) : c >> 1;
      return c;
   endfunction
   // ==========
   // Queue a frame; mode 1 shares a zero, 8 shares a flag
   task automatic put(input logic [7:0] a, input int len, input int mode,
                      input logic bad);
      logic [7:0]  f[$];
      logic [31:0] c;
      int          k;
      f = {a, 8'h10};
      for (int i = 0; i < len; i++)
         f.push_back(i == 0 ? 8'hFF : 8'(i) + 8'h30);
      c = ~crc(f);
      c[0] = c[0] ^ bad;
      for (int i = 0; i < (fcs32 ? 4 : 2); i++)
         f.push_back(c[8*i +: 8]);
      for (int i = mode; i < 8; i++)
         bq.push_back(FLAG[i]);
      k = 0;
      foreach (f[j])
         for (int i = 0; i < 8; i++)
         begin
            bq.push_back(f[j][i]);
            k = f[j][i] ? k + 1 : 0;
            if (k == 5)
               bq.push_back(1'b0);
            k = k % 5;
         end
      for (int i = 0; i < 8; i++)
         bq.push_back(FLAG[i]);
   endtask
   // ==========
   // Send side, idle flags between frames
   always @(negedge line_clk)
   begin
      if (bq.size() == 0)
         for (int i = 0; i < 8; i++)
            bq.push_back(FLAG[i]);
      tb_bit = bq.pop_front();
      lv = nrzi ? lv ^ ~tb_bit : tb_bit;
      line_rxd <= lv;
   end
   // ==========
   // Receive side, deframe and check
   always @(posedge line_clk)
   begin
      rb = nrzi ? (line_txd == pv) : line_txd;
      pv = line_txd;
      sh = {rb, sh[7:1]};
      if (sh == FLAG)
      begin
         if (cur.size() >= 3)
         begin
            fb = cur;
            gap = fl;
            fl = 0;
            fok = crc(cur) == (fcs32 ? `LFR_RES32 : `LFR_RES16);
            nfr++;
         end
         fl++;
         cur = {};
         nb = 0;
         on = 0;
      end
      else if (on == 5 && !rb)
         on = 0;
      else
      begin
         on = rb ? on + 1 : 0;
         acc = {rb, acc[7:1]};
         nb++;
         if (nb % 8 == 0)
            cur.push_back(acc);
      end
   end
endmodule // lfr_dev
`default_nettype wire

// file: tb/lfr_host_tb_top.sv
// lfr_host_tb_top.sv: self-checking bench of the frame host
// Assumes lfr_dev as far station and lfr_props bound to the host
`timescale 1ns/10ps
`default_nettype none
`include "lfr_defs.svh"
module lfr_host_tb_top
   import lfr_pkg::*;
;
   typedef struct packed {
      logic [2:0]  ctrl;
      logic [31:0] cmd;
      logic [8:0]  pay;
      logic [7:0]  a;
      logic [7:0]  c0;
      logic [7:0]  c1;
   } lfr_row_t;
   lfr_row_t rows [6] = '{
      '{3'h0, 32'h8000185C, 9'h1FF, 8'h03, 8'h7A, 8'h00},
      '{3'h2, 32'h80083001, 9'h000, 8'h01, 8'hC9, 8'h00},
      '{3'h5, 32'h8170000E, 9'h000, 8'h03, 8'hBF, 8'h00},
      '{3'h7, 32'h80026E48, 9'h13C, 8'h01, 8'hC8, 8'h9B},
      '{3'h1, 32'h8007F805, 9'h000, 8'h03, 8'h05, 8'hFE},
      '{3'h4, 32'h80003874, 9'h000, 8'h03, 8'hEE, 8'h00}};
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [2:0]  mode_r = 3'h0;
   logic [31:0] reg_rdata, d;
   logic        line_clk, line_txd, line_rxd;
   int          mismatches = 0;
   int          checks = 0;
   int          n0, nc;
   always #50 clk = ~clk;
   lfr_host #(.LINE_DIV(8)) uut (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_clk(line_clk),
      .line_txd(line_txd), .line_rxd(line_rxd));
   lfr_dev dev (.line_clk(line_clk), .line_txd(line_txd),
      .line_rxd(line_rxd), .nrzi(mode_r[1]), .fcs32(mode_r[2]));
   // ==========
   // Tasks
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] s);
      checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   task automatic poll(input string n, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
      rd(a);
      for (int i = 0; i < 3000; i++)
         if ((d & m) !== e)
            rd(a);
      chk(n, e, d & m);
   endtask
   task automatic wait_frame(input int k);
      for (int i = 0; i < 4000 && dev.nfr < k; i++)
         @(posedge clk);
      chk("frame seen", 1, dev.nfr >= k);
   endtask
   task automatic rxc(input logic [7:0] a, input int len, input int md,
                      input logic bad, input logic [31:0] e);
      wr(`LFR_OFF_STAT, 32'h000000F8);
      dev.put(a, len, md, bad);
      poll("stat", `LFR_OFF_STAT, 32'h00000138, e);
      $display("receive test addr %h done", a);
   endtask
   // ==========
   // Watchdog
   initial
   begin
      #(100 * 60000);
      mismatches++;
      finish_test();
   end
   // ==========
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      wr(`LFR_OFF_ADDR, 32'h00000103);
      chk("addr reg", 32'h00000103, d);
      rd(8'h40);
      chk("unmapped", 32'h0, d);
      foreach (rows[i])
      begin
         mode_r = rows[i].ctrl;
         wr(`LFR_OFF_CTRL, 32'(rows[i].ctrl));
         chk("ctrl reg", 32'(rows[i].ctrl), d);
         wr(`LFR_OFF_TXLEN, 32'(rows[i].pay[8]));
         if (rows[i].pay[8])
            wr(`LFR_OFF_TXDATA, 32'(rows[i].pay[7:0]));
         n0 = dev.nfr;
         wr(`LFR_OFF_TXCMD, rows[i].cmd);
         wait_frame(n0 + 1);
         nc = (rows[i].ctrl[0] && rows[i].cmd[1:0] != 2'h2) ? 2 : 1;
         chk("length", 1 + nc + rows[i].pay[8] + (rows[i].ctrl[2] ? 4 : 2),
             dev.fb.size());
         chk("address", rows[i].a, dev.fb[0]);
         chk("control", rows[i].c0, dev.fb[1]);
         if (nc == 2)
            chk("control hi", rows[i].c1, dev.fb[2]);
         if (rows[i].pay[8])
            chk("payload", rows[i].pay[7:0], dev.fb[1 + nc]);
         chk("fcs", 1, dev.fok);
         $display("transmit row %0d done", i);
      end
      n0 = dev.nfr;
      wr(`LFR_OFF_TXCMD, rows[5].cmd);
      poll("busy", `LFR_OFF_STAT, 32'h1, 32'h0);
      wr(`LFR_OFF_TXCMD, rows[0].cmd);
      wait_frame(n0 + 2);
      chk("flag gap", 1, dev.gap >= 2);
      $display("back to back transmit done");
      mode_r = 3'h0;
      wr(`LFR_OFF_CTRL, 32'h0);
      rxc(8'h01, 2, 0, 1'b0, 32'h00000108);
      rd(`LFR_OFF_RXCTL);
      chk("rx control", 32'h10, d);
      rxc(8'h03, 1, 0, 1'b0, 32'h00000008);
      rxc(8'h55, 1, 0, 1'b0, 32'h00000020);
      rxc(8'h01, 1, 0, 1'b1, 32'h00000010);
      dev.put(8'h01, 1, 0, 1'b0);
      rxc(8'h01, 3, 8, 1'b0, 32'h00000108);
      poll("rx len", `LFR_OFF_RXLEN, 32'h00FFFFFF, 32'h00010003);
      dev.put(8'h01, 2, 0, 1'b0);
      rxc(8'h01, 4, 1, 1'b0, 32'h00000108);
      poll("rx len", `LFR_OFF_RXLEN, 32'h00FFFFFF, 32'h00010004);
      mode_r = 3'h7;
      wr(`LFR_OFF_CTRL, 32'h7);
      rxc(8'h03, 3, 0, 1'b0, 32'h00000008);
      poll("rx len", `LFR_OFF_RXLEN, 32'h00FFFFFF, 32'h00030002);
      rd(`LFR_OFF_RXCTL);
      chk("rx control ext", 32'h0000FF10, d);
      @(posedge clk);
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(`LFR_OFF_CTRL);
      chk("ctrl reset", 32'h0, d);
      rd(`LFR_OFF_STAT);
      chk("stat reset", 32'h00000002, d);
      $display("reset test done");
      finish_test();
   end
endmodule // lfr_host_tb_top
`default_nettype wire
